// ===== design/flash_host.sv
`timescale 1ns/1ps
`default_nettype none

module flash_host #(
    parameter int wake_count = flash_host_pkg::wake_cycles
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flash_host_pkg::flash_pins_s pins,
    input wire logic [7:0] flash_data_in
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        flash_host_pkg::host_state_e st;
        logic [3:0] op;
        logic hv;
        logic [19:0] addr;
        logic [7:0] data;
        logic [7:0] rdata;
        logic second;
        logic [15:0] cnt;
        logic done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        flash_host_pkg::flash_pins_s pins;
    } host_s;

    host_s s_q;
    host_s s_d;

    function automatic logic [7:0] first_code(input logic [3:0] op);
        case (op)
            flash_host_pkg::op_read_array: first_code = flash_host_pkg::cmd_read_array;
            flash_host_pkg::op_read_id: first_code = flash_host_pkg::cmd_read_id;
            flash_host_pkg::op_read_status: first_code = flash_host_pkg::cmd_read_status;
            flash_host_pkg::op_clear_status: first_code = flash_host_pkg::cmd_clear_status;
            flash_host_pkg::op_erase: first_code = flash_host_pkg::cmd_erase_setup;
            flash_host_pkg::op_byte_write: first_code = flash_host_pkg::cmd_write_setup;
            flash_host_pkg::op_suspend: first_code = flash_host_pkg::cmd_suspend;
            flash_host_pkg::op_resume: first_code = flash_host_pkg::cmd_confirm;
            default: first_code = flash_host_pkg::cmd_lock_setup;
        endcase
    endfunction

    function automatic logic two_step(input logic [3:0] op);
        two_step = (op == flash_host_pkg::op_erase) || (op == flash_host_pkg::op_byte_write)
            || (op == flash_host_pkg::op_set_block_lock)
            || (op == flash_host_pkg::op_set_master_lock)
            || (op == flash_host_pkg::op_clear_locks);
    endfunction

    function automatic logic [7:0] second_code(input logic [3:0] op, input logic [7:0] d);
        case (op)
            flash_host_pkg::op_byte_write: second_code = d;
            flash_host_pkg::op_set_block_lock: second_code = flash_host_pkg::cmd_set_block_lock;
            flash_host_pkg::op_set_master_lock: second_code = flash_host_pkg::cmd_set_master_lock;
            default: second_code = flash_host_pkg::cmd_confirm;
        endcase
    endfunction

    logic setup_phase;
    logic wr;
    logic rd;
    logic known_op;
    assign setup_phase = psel & ~penable;
    assign wr = setup_phase & pwrite;
    assign rd = setup_phase & ~pwrite;
    // Codes outside the defined set are never put on the bus
    assign known_op = (pwdata[3:0] <= flash_host_pkg::op_wake);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        // APB: no wait state, answer in the cycle after setup
        if (setup_phase) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            case (paddr)
                flash_host_pkg::ctrl_off: begin
                    s_d.prdata = {26'h0, s_q.hv, 1'b0, s_q.op};
                    if (wr) begin
                        if (pwdata[flash_host_pkg::ctrl_go_bit]) begin
                            if (s_q.st != flash_host_pkg::st_idle || !known_op) begin
                                s_d.pslverr = 1'b1;
                            end else begin
                                // Override request only changes with an accepted order
                                s_d.hv = pwdata[flash_host_pkg::ctrl_hv_bit];
                                s_d.op = pwdata[3:0];
                                s_d.done = 1'b0;
                                s_d.second = 1'b0;
                                s_d.cnt = 16'h0;
                                if (pwdata[3:0] == flash_host_pkg::op_read) begin
                                    s_d.st = flash_host_pkg::st_r_setup;
                                end else if (pwdata[3:0] == flash_host_pkg::op_powerdown) begin
                                    s_d.st = flash_host_pkg::st_pd_hold;
                                end else if (pwdata[3:0] == flash_host_pkg::op_wake) begin
                                    s_d.st = flash_host_pkg::st_wake;
                                end else begin
                                    s_d.st = flash_host_pkg::st_w_setup;
                                end
                            end
                        end
                    end
                end
                flash_host_pkg::addr_off: begin
                    s_d.prdata = {12'h0, s_q.addr};
                    if (wr) begin
                        s_d.addr = pwdata[19:0];
                    end
                end
                flash_host_pkg::data_off: begin
                    s_d.prdata = {24'h0, s_q.data};
                    if (wr) begin
                        s_d.data = pwdata[7:0];
                    end
                end
                flash_host_pkg::stat_off: begin
                    s_d.prdata = {29'h0, s_q.pins.reset_powerdown_low & (s_q.st != flash_host_pkg::st_wake),
                                  s_q.done, s_q.st != flash_host_pkg::st_idle};
                end
                flash_host_pkg::rdat_off: begin
                    s_d.prdata = {24'h0, s_q.rdata};
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
            if (rd && s_d.pslverr) begin
                s_d.prdata = 32'h0000_0000;
            end
        end

        // Override level requested after any accepted order with the hv bit set, while the reset pin is high
        // Dropped with the reset pin, never a cycle after it
        s_d.pins.override_high_level = s_q.hv && s_q.pins.reset_powerdown_low
            && (s_q.st != flash_host_pkg::st_pd_hold);

        case (s_q.st)
            flash_host_pkg::st_idle: begin
                s_d.pins.chip_select_n = 1'b1;
                s_d.pins.output_gate_n = 1'b1;
                s_d.pins.write_strobe_n = 1'b1;
                s_d.pins.data_oe = 1'b0;
            end
            flash_host_pkg::st_w_setup: begin
                // Gate stays high so it never overlaps the strobe
                s_d.pins.output_gate_n = 1'b1;
                s_d.pins.chip_select_n = 1'b0;
                s_d.pins.address = s_q.addr;
                s_d.pins.data_out = s_q.second ? second_code(s_q.op, s_q.data)
                                               : first_code(s_q.op);
                s_d.pins.data_oe = 1'b1;
                s_d.cnt = 16'h0;
                s_d.st = flash_host_pkg::st_w_strobe;
            end
            flash_host_pkg::st_w_strobe: begin
                s_d.pins.write_strobe_n = 1'b0;
                s_d.cnt = s_q.cnt + 16'h1;
                if (s_q.cnt == 16'(flash_host_pkg::strobe_cycles - 1)) begin
                    s_d.st = flash_host_pkg::st_w_hold;
                end
            end
            flash_host_pkg::st_w_hold: begin
                // Strobe rises first; address and data still held
                s_d.pins.write_strobe_n = 1'b1;
                s_d.st = flash_host_pkg::st_gap;
            end
            flash_host_pkg::st_gap: begin
                s_d.pins.chip_select_n = 1'b1;
                s_d.pins.data_oe = 1'b0;
                if (!s_q.second && two_step(s_q.op)) begin
                    s_d.second = 1'b1;
                    s_d.st = flash_host_pkg::st_w_setup;
                end else begin
                    s_d.done = 1'b1;
                    s_d.st = flash_host_pkg::st_idle;
                end
            end
            flash_host_pkg::st_r_setup: begin
                s_d.pins.write_strobe_n = 1'b1;
                s_d.pins.data_oe = 1'b0;
                s_d.pins.address = s_q.addr;
                s_d.pins.chip_select_n = 1'b0;
                s_d.cnt = 16'h0;
                s_d.st = flash_host_pkg::st_r_wait;
            end
            flash_host_pkg::st_r_wait: begin
                s_d.pins.output_gate_n = 1'b0;
                s_d.cnt = s_q.cnt + 16'h1;
                if (s_q.cnt == 16'(flash_host_pkg::read_cycles - 1)) begin
                    s_d.rdata = flash_data_in;
                    s_d.st = flash_host_pkg::st_r_end;
                end
            end
            flash_host_pkg::st_r_end: begin
                s_d.pins.output_gate_n = 1'b1;
                s_d.pins.chip_select_n = 1'b1;
                s_d.done = 1'b1;
                s_d.st = flash_host_pkg::st_idle;
            end
            flash_host_pkg::st_pd_hold: begin
                // Low is held at least the minimum, then until a wake order
                s_d.pins.chip_select_n = 1'b1;
                s_d.pins.output_gate_n = 1'b1;
                s_d.pins.data_oe = 1'b0;
                s_d.pins.reset_powerdown_low = 1'b0;
                s_d.cnt = s_q.cnt + 16'h1;
                if (s_q.cnt == 16'(flash_host_pkg::powerdown_cycles - 1)) begin
                    s_d.done = 1'b1;
                    s_d.st = flash_host_pkg::st_idle;
                end
            end
            flash_host_pkg::st_wake: begin
                s_d.pins.reset_powerdown_low = 1'b1;
                s_d.cnt = s_q.cnt + 16'h1;
                // Device comes back in array mode; no command needed
                if (s_q.cnt == 16'(wake_count - 1)) begin
                    s_d.done = 1'b1;
                    s_d.st = flash_host_pkg::st_idle;
                end
            end
            default: begin
                s_d.st = flash_host_pkg::st_idle;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset pin tracks presetn through this flop, as with a CPU reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= flash_host_pkg::st_wake;
            s_q.pins.chip_select_n <= 1'b1;
            s_q.pins.output_gate_n <= 1'b1;
            s_q.pins.write_strobe_n <= 1'b1;
            s_q.pins.reset_powerdown_low <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pins = s_q.pins;

endmodule

`default_nettype wire

// ===== common/flash_host_pkg.sv
package flash_host_pkg;

    // ------------------------------------------------------------
    // Register map of the host controller (APB, byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] addr_off = 12'h004;
    localparam logic [11:0] data_off = 12'h008;
    localparam logic [11:0] stat_off = 12'h00c;
    localparam logic [11:0] rdat_off = 12'h010;

    // Control register fields
    localparam int ctrl_op_lsb = 0;
    localparam int ctrl_op_w = 4;
    localparam int ctrl_go_bit = 4;
    localparam int ctrl_hv_bit = 5;

    // Status register fields
    localparam int stat_busy_bit = 0;
    localparam int stat_done_bit = 1;
    localparam int stat_wake_bit = 2;

    // ------------------------------------------------------------
    // Operations software can order
    // ------------------------------------------------------------
    localparam logic [3:0] op_read = 4'h0;
    localparam logic [3:0] op_read_array = 4'h1;
    localparam logic [3:0] op_read_id = 4'h2;
    localparam logic [3:0] op_read_status = 4'h3;
    localparam logic [3:0] op_clear_status = 4'h4;
    localparam logic [3:0] op_erase = 4'h5;
    localparam logic [3:0] op_byte_write = 4'h6;
    localparam logic [3:0] op_suspend = 4'h7;
    localparam logic [3:0] op_resume = 4'h8;
    localparam logic [3:0] op_set_block_lock = 4'h9;
    localparam logic [3:0] op_set_master_lock = 4'ha;
    localparam logic [3:0] op_clear_locks = 4'hb;
    localparam logic [3:0] op_powerdown = 4'hc;
    localparam logic [3:0] op_wake = 4'hd;

    // ------------------------------------------------------------
    // Device command codes
    // ------------------------------------------------------------
    localparam logic [7:0] cmd_read_array = 8'hff;
    localparam logic [7:0] cmd_read_id = 8'h90;
    localparam logic [7:0] cmd_read_status = 8'h70;
    localparam logic [7:0] cmd_clear_status = 8'h50;
    localparam logic [7:0] cmd_erase_setup = 8'h20;
    localparam logic [7:0] cmd_confirm = 8'hd0;
    localparam logic [7:0] cmd_write_setup = 8'h40;
    localparam logic [7:0] cmd_write_setup_alt = 8'h10;
    localparam logic [7:0] cmd_suspend = 8'hb0;
    localparam logic [7:0] cmd_lock_setup = 8'h60;
    localparam logic [7:0] cmd_set_block_lock = 8'h01;
    localparam logic [7:0] cmd_set_master_lock = 8'hf1;
    localparam logic [7:0] status_after_wake = 8'h80;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int clk_ns = 40;
    localparam int powerdown_min_ns = 100;
    localparam int powerdown_cycles = (powerdown_min_ns + clk_ns - 1) / clk_ns;
    localparam int wake_before_write_ns = 1000;
    localparam int wake_cycles = (wake_before_write_ns + clk_ns - 1) / clk_ns;
    localparam int strobe_cycles = 3;
    localparam int read_cycles = 4;

    // ------------------------------------------------------------
    // Pin bundle toward the flash
    // ------------------------------------------------------------
    typedef struct packed {
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic reset_powerdown_low;
        logic override_high_level;
        logic [19:0] address;
        logic [7:0] data_out;
        logic data_oe;
    } flash_pins_s;

    typedef enum logic [3:0] {
        st_idle,
        st_w_setup,
        st_w_strobe,
        st_w_hold,
        st_gap,
        st_r_setup,
        st_r_wait,
        st_r_end,
        st_pd_hold,
        st_wake
    } host_state_e;

endpackage

// ===== bench/flash_host_props.sv
`timescale 1ns/1ps
`default_nettype none

module flash_host_props #(
    parameter int wake_count = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire flash_host_pkg::flash_pins_s pins
);
    // ------------------------------------------------------------
    // Cycles since the reset pin last rose
    // ------------------------------------------------------------
    int awake_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_q <= 0;
        end else if (!pins.reset_powerdown_low) begin
            awake_q <= 0;
        end else if (awake_q < 4000) begin
            awake_q <= awake_q + 1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Pin sequencing
    // ------------------------------------------------------------
    AST_NO_OVERLAP: assert property (!(!pins.output_gate_n && !pins.write_strobe_n))
        else $error("gate and strobe low together");
    AST_READ_PINS: assert property (!pins.output_gate_n |-> !pins.chip_select_n
        && pins.write_strobe_n && pins.reset_powerdown_low && !pins.data_oe)
        else $error("read pins wrong");
    AST_READ_LEN: assert property ($fell(pins.output_gate_n) |->
        !pins.output_gate_n [*4] ##1 pins.output_gate_n)
        else $error("gate low length wrong");
    AST_WRITE_PINS: assert property (!pins.write_strobe_n |-> !pins.chip_select_n
        && pins.data_oe && pins.reset_powerdown_low)
        else $error("write pins wrong");
    AST_STROBE_LEN: assert property ($fell(pins.write_strobe_n) |->
        !pins.write_strobe_n [*3] ##1 (pins.write_strobe_n && !pins.chip_select_n))
        else $error("strobe length or release order wrong");
    AST_LATCH_STABLE: assert property (!pins.write_strobe_n |=>
        $stable(pins.address) && $stable(pins.data_out))
        else $error("address or data moved under strobe");
    AST_PD_WIDTH: assert property ($fell(pins.reset_powerdown_low) |->
        !pins.reset_powerdown_low [*3])
        else $error("power-down pulse too short");
    AST_PD_IDLE: assert property (!pins.reset_powerdown_low |-> pins.chip_select_n
        && pins.output_gate_n && pins.write_strobe_n && !pins.data_oe)
        else $error("bus active in power-down");
    // Wake gap is a counter: the figure is a parameter, too long to unroll
    AST_WAKE_GAP: assert property (!pins.write_strobe_n |-> awake_q >= wake_count)
        else $error("command too soon after wake");
    AST_OVERRIDE: assert property (pins.override_high_level |-> pins.reset_powerdown_low)
        else $error("override while pin low");
endmodule

bind flash_host flash_host_props #(.wake_count(wake_count)) u_props (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins)
);

`default_nettype wire

// ===== bench/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model #(
    parameter logic [7:0] id_code = 8'h3c
) (
    input wire flash_host_pkg::flash_pins_s pins,
    output logic [7:0] flash_data_in
);
    // ------------------------------------------------------------
    // Command decoder; operations finish at once, so no busy time
    // ------------------------------------------------------------
    logic [7:0] mode_q, pend_q, stat_q, val;
    logic [15:0] hist_q;
    int n_wr;

    initial begin
        mode_q = 8'hff;
        pend_q = 8'h00;
        stat_q = 8'h80;
        hist_q = 16'h0;
        n_wr = 0;
    end

    always @(posedge pins.write_strobe_n or negedge pins.reset_powerdown_low) begin
        if (!pins.reset_powerdown_low) begin
            mode_q = 8'hff;
            pend_q = 8'h00;
            stat_q = 8'h80;
        end else if (!pins.chip_select_n) begin
            hist_q = {hist_q[7:0], pins.data_out};
            n_wr++;
            if (pend_q != 8'h00) begin
                mode_q = 8'h70;
                pend_q = 8'h00;
            end else begin
                case (pins.data_out)
                    8'hff, 8'h90, 8'h70: mode_q = pins.data_out;
                    8'h50: stat_q = 8'h80;
                    8'hb0: mode_q = 8'h70;
                    8'h20, 8'h40, 8'h10, 8'h60: pend_q = pins.data_out;
                    default: pend_q = 8'h00;
                endcase
            end
        end
    end

    // Released bus shows the inverse, so a late sample cannot pass by luck
    assign val = (mode_q == 8'hff) ? (pins.address[7:0] ^ 8'h5a) :
        (mode_q == 8'h90) ? id_code : stat_q;
    assign flash_data_in = (!pins.chip_select_n && !pins.output_gate_n
        && pins.reset_powerdown_low) ? val : ~val;
endmodule

`default_nettype wire

// ===== bench/flash_host_tb.sv
`timescale 1ns/1ps
`default_nettype none

module flash_host_tb;
    localparam logic [7:0] id_code = 8'h3c; // Arbitrary identifier value
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hv_seen, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] fdata;
    flash_host_pkg::flash_pins_s pins;
    int error_cnt, n_checks, n0, d;

    flash_host #(.wake_count(2)) u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .pins(pins),
        .flash_data_in(fdata)
    );
    flash_dev_model #(.id_code(id_code)) u_dev (.pins(pins), .flash_data_in(fdata));

    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (pins.override_high_level === 1'b1) hv_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) fail(m);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail("no pready");
            close_out();
        end
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, flash_host_pkg::stat_off, 32'h0);
            k++;
        end while (r[0] !== 1'b0 && k < 200);
        if (r[0] !== 1'b0) begin
            fail("busy stuck");
            close_out();
        end
    endtask
    task automatic run(input logic [3:0] op, input logic hv);
        apb(1'b1, flash_host_pkg::ctrl_off, {26'h0, hv, 1'b1, op});
        chk({31'h0, e}, 32'h0, "go refused");
        wait_idle();
    endtask
    task automatic read_chk(input logic [7:0] x, input string m);
        run(flash_host_pkg::op_read, 1'b0);
        apb(1'b0, flash_host_pkg::rdat_off, 32'h0);
        chk(r, {24'h0, x}, m);
    endtask
    function automatic logic [31:0] cmd_of(input logic [3:0] op);
        case (op)
            4'h1: return 32'h100ff;
            4'h2: return 32'h10090;
            4'h3: return 32'h10070;
            4'h4: return 32'h10050;
            4'h5: return 32'h220d0;
            4'h6: return 32'h240a7;
            4'h7: return 32'h100b0;
            4'h8: return 32'h100d0;
            4'h9: return 32'h26001;
            4'ha: return 32'h260f1;
            default: return 32'h260d0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hv_seen = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_idle();
        chk(r, 32'h6, "status after reset");
        apb(1'b1, flash_host_pkg::addr_off, 32'h12345);
        apb(1'b1, flash_host_pkg::data_off, 32'ha7);
        read_chk(8'h1f, "array after power-up");
        apb(1'b0, 12'h014, 32'h0);
        chk({e, r[30:0]}, 32'h80000000, "unmapped access");
        $display("test reset done");
        for (int i = 1; i <= 11; i++) begin
            n0 = u_dev.n_wr;
            run(i[3:0], 1'b0);
            d = u_dev.n_wr - n0;
            r = {14'h0, d[1:0], (d == 2) ? u_dev.hist_q[15:8] : 8'h00, u_dev.hist_q[7:0]};
            chk(r, cmd_of(i[3:0]), "command bytes");
            read_chk((i == 1) ? 8'h1f : (i == 2) ? id_code : 8'h80, "read mode");
        end
        $display("test commands done");
        run(flash_host_pkg::op_powerdown, 1'b0);
        chk({31'h0, pins.reset_powerdown_low}, 32'h0, "pin not low");
        run(flash_host_pkg::op_wake, 1'b0);
        read_chk(8'h1f, "array after wake");
        run(flash_host_pkg::op_read_status, 1'b0);
        read_chk(8'h80, "status after wake");
        $display("test power-down done");
        chk({31'h0, hv_seen}, 32'h0, "override unasked");
        n0 = u_dev.n_wr;
        apb(1'b1, flash_host_pkg::ctrl_off, 32'h1e);
        chk({31'h0, e}, 32'h1, "bad op taken");
        apb(1'b1, flash_host_pkg::ctrl_off, 32'h35);
        apb(1'b1, flash_host_pkg::ctrl_off, 32'h11);
        chk({31'h0, e}, 32'h1, "go while busy taken");
        wait_idle();
        chk(32'(u_dev.n_wr - n0), 32'h2, "write count");
        chk({31'h0, hv_seen}, 32'h1, "override missing");
        $display("test refusals done");
        close_out();
    end
endmodule

`default_nettype wire
